/* hw/exrg_top.sv */
// Excitation routing and digital pin configuration register bank.
// Assumes a same-clock register port (one-cycle write and read strobes);
// pin input levels come from pads and are synchronised here.
`timescale 1ns/1ps
module exrg_top
  import exrg_pkg::*;
#(
  parameter bit WIDE = 1'b1
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic [EXRG_AW-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [EXRG_DW-1:0] reg_wdata_i,
  input wire logic [2:0] source_magnitude_i,
  input wire logic [EXRG_NPIN-1:0] pin_value_i,
  output logic [EXRG_DW-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output exrg_route_s first_route_o,
  output exrg_route_s second_route_o,
  output exrg_pins_s pins_o
);

  logic [7:0] route_q, route_d;
  logic [7:0] pin_en_q, pin_en_d;
  logic [7:0] pin_dir_q, pin_dir_d;
  logic [7:0] pin_val_q, pin_val_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  exrg_route_s first_q, first_d, second_q, second_d;
  exrg_pins_s pins_q, pins_d;
  logic [EXRG_NPIN-1:0] pin_sync1_q, pin_sync2_q;
  exrg_route_s first_raw, second_raw;
  logic [7:0] route_eff;
  logic [EXRG_SEL_W-1:0] first_sel, second_sel;
  logic [7:0] pin_mask;

  // Applies the narrow-part write mask to a pin register
  function automatic logic [7:0] pin_wr(input logic [7:0] v,
                                        input logic [7:0] m);
    pin_wr = v & m;
  endfunction

  // Narrow selectors: stored 2 bits with fixed ones above
  function automatic logic [3:0] narrow_sel(input logic [3:0] v);
    narrow_sel = (v & EXRG_NARROW_SEL_MASK) | EXRG_NARROW_FIXED;
  endfunction

  // Code a narrow selector decodes: its 2 stored bits, upper bits clear
  function automatic logic [3:0] narrow_code(input logic [3:0] v);
    narrow_code = v & EXRG_NARROW_SEL_MASK;
  endfunction

  assign pin_mask = WIDE ? 8'hff : EXRG_NARROW_PIN_MASK;

  always_comb
  begin
    route_eff = route_q;
    if (!WIDE)
    begin
      route_eff = {narrow_sel(route_q[7:4]), narrow_sel(route_q[3:0])};
    end
  end

  // Fixed readback ones are not part of a narrow code; decoding them
  // would leave both narrow sources cut off for good
  always_comb
  begin
    first_sel = route_q[EXRG_FIRST_LSB +: EXRG_SEL_W];
    second_sel = route_q[EXRG_SECOND_LSB +: EXRG_SEL_W];
    if (!WIDE)
    begin
      first_sel = narrow_code(route_q[EXRG_FIRST_LSB +: EXRG_SEL_W]);
      second_sel = narrow_code(route_q[EXRG_SECOND_LSB +: EXRG_SEL_W]);
    end
  end

  // Register writes land immediately; the muxing follows on the next edge
  always_comb
  begin
    route_d = route_q;
    pin_en_d = pin_en_q;
    pin_dir_d = pin_dir_q;
    pin_val_d = pin_val_q;
    if (reg_wr_i)
    begin
      if (reg_addr_i == EXRG_OFF_ROUTE)
      begin
        route_d = reg_wdata_i;
      end
      else if (reg_addr_i == EXRG_OFF_PIN_EN)
      begin
        pin_en_d = pin_wr(reg_wdata_i, pin_mask);
      end
      else if (reg_addr_i == EXRG_OFF_PIN_DIR)
      begin
        pin_dir_d = pin_wr(reg_wdata_i, pin_mask);
      end
      else if (reg_addr_i == EXRG_OFF_PIN_VAL)
      begin
        pin_val_d = pin_wr(reg_wdata_i, pin_mask);
      end
    end
  end

  always_comb
  begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd_i;
    if (reg_rd_i)
    begin
      if (reg_addr_i == EXRG_OFF_ROUTE)
      begin
        rdata_d = route_eff;
      end
      else if (reg_addr_i == EXRG_OFF_PIN_EN)
      begin
        rdata_d = pin_en_q;
      end
      else if (reg_addr_i == EXRG_OFF_PIN_DIR)
      begin
        rdata_d = pin_dir_q;
      end
      else if (reg_addr_i == EXRG_OFF_PIN_VAL)
      begin
        // Outputs return the held value, inputs the pad level
        rdata_d = ((pin_val_q & ~pin_dir_q)
                  | (pin_sync2_q & pin_dir_q)) & pin_mask;
      end
      else
      begin
        rdata_d = 8'h00;
      end
    end
  end

  exrg_route_dec u_first_dec (
    .sel_i(first_sel),
    .wide_i(WIDE),
    .route_o(first_raw)
  );

  exrg_route_dec u_second_dec (
    .sel_i(second_sel),
    .wide_i(WIDE),
    .route_o(second_raw)
  );

  // Destinations stay open while the magnitude code keeps the sources off
  always_comb
  begin
    first_d = '0;
    second_d = '0;
    if (source_magnitude_i != EXRG_MAG_OFF)
    begin
      first_d = first_raw;
      second_d = second_raw;
    end
  end

  // Bit 0 positive reference, bit 1 negative reference, 2..7 inputs
  always_comb
  begin
    pins_d.digital_enable = pin_en_q;
    pins_d.drive_value = pin_val_q & pin_en_q;
    pins_d.drive_enable = pin_en_q & ~pin_dir_q;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      route_q <= EXRG_RST_ROUTE;
      pin_en_q <= EXRG_RST_PIN_EN;
      pin_dir_q <= EXRG_RST_PIN_DIR;
      pin_val_q <= EXRG_RST_PIN_VAL;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      first_q <= '0;
      second_q <= '0;
      pins_q <= '0;
      pin_sync1_q <= '0;
      pin_sync2_q <= '0;
    end
    else if (clk_en_i)
    begin
      route_q <= route_d;
      pin_en_q <= pin_en_d;
      pin_dir_q <= pin_dir_d;
      pin_val_q <= pin_val_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      first_q <= first_d;
      second_q <= second_d;
      pins_q <= pins_d;
      pin_sync1_q <= pin_value_i;
      pin_sync2_q <= pin_sync1_q;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign first_route_o = first_q;
  assign second_route_o = second_q;
  assign pins_o = pins_q;

endmodule

/* hw/exrg_pkg.sv */
// Package for the excitation routing and digital pin configuration bank.
// Assumes an 8-bit register port driven from the device's own clock domain.
package exrg_pkg;

  localparam int unsigned EXRG_DW = 8;
  localparam int unsigned EXRG_AW = 8;
  localparam int unsigned EXRG_NPIN = 8;
  localparam int unsigned EXRG_NPIN_NARROW = 4;
  localparam int unsigned EXRG_NAIN = 8;

  localparam logic [7:0] EXRG_OFF_ROUTE = 8'h0b;
  localparam logic [7:0] EXRG_OFF_PIN_EN = 8'h0c;
  localparam logic [7:0] EXRG_OFF_PIN_DIR = 8'h0d;
  localparam logic [7:0] EXRG_OFF_PIN_VAL = 8'h0e;

  localparam logic [7:0] EXRG_RST_ROUTE = 8'hff;
  localparam logic [7:0] EXRG_RST_PIN_EN = 8'h00;
  localparam logic [7:0] EXRG_RST_PIN_DIR = 8'h00;
  localparam logic [7:0] EXRG_RST_PIN_VAL = 8'h00;
  localparam logic [2:0] EXRG_RST_MAG = 3'h0;
  localparam logic [2:0] EXRG_MAG_OFF = 3'h0;

  // Field positions in the routing register
  localparam int unsigned EXRG_FIRST_LSB = 4;
  localparam int unsigned EXRG_SECOND_LSB = 0;
  localparam int unsigned EXRG_SEL_W = 4;
  // Narrow variant: writable low bits of each nibble, fixed ones above
  localparam logic [3:0] EXRG_NARROW_SEL_MASK = 4'h3;
  localparam logic [3:0] EXRG_NARROW_FIXED = 4'hc;
  localparam logic [7:0] EXRG_NARROW_PIN_MASK = 8'h0f;

  // Selector top bits that pick the destination class
  localparam logic [1:0] EXRG_CLS_AIN_A = 2'h0;
  localparam logic [1:0] EXRG_CLS_AIN_B = 2'h1;
  localparam logic [1:0] EXRG_CLS_EXCITE = 2'h2;

  typedef struct packed {
    logic [EXRG_NAIN-1:0] analog_input;
    logic excite_pin_a;
    logic excite_pin_b;
  } exrg_route_s;

  typedef struct packed {
    logic [EXRG_NPIN-1:0] digital_enable;
    logic [EXRG_NPIN-1:0] drive_value;
    logic [EXRG_NPIN-1:0] drive_enable;
  } exrg_pins_s;

endpackage

/* hw/exrg_route_dec.sv */
// Decodes one 4-bit selector into a one-hot destination, or none, for a current source.
// Assumes the caller gates the result with the source's magnitude.
`timescale 1ns/1ps
module exrg_route_dec
  import exrg_pkg::*;
(
  input wire logic [EXRG_SEL_W-1:0] sel_i,
  input wire logic wide_i,
  output exrg_route_s route_o
);

  always_comb
  begin
    route_o = '0;
    case (sel_i[3:2])
      EXRG_CLS_AIN_A:
      begin
        route_o.analog_input[sel_i[2:0]] = 1'b1;
      end
      EXRG_CLS_AIN_B:
      begin
        // Inputs 4 to 7 exist only on the wide part
        route_o.analog_input[sel_i[2:0]] = wide_i;
      end
      EXRG_CLS_EXCITE:
      begin
        // Bit 1 ignored
        route_o.excite_pin_a = wide_i & ~sel_i[0];
        route_o.excite_pin_b = wide_i & sel_i[0];
      end
      default:
      begin
        route_o = '0;
      end
    endcase
  end

endmodule

/* verif/exrg_top_assertions.sv */
// Checker for the routing and pin bank, bound into every instance.
// Sees only the top module's ports.
`timescale 1ns/1ps
module exrg_top_checker
  import exrg_pkg::*;
#(
  parameter bit WIDE = 1'b1
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic [EXRG_AW-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [EXRG_DW-1:0] reg_wdata_i,
  input wire logic [2:0] source_magnitude_i,
  input wire logic [EXRG_NPIN-1:0] pin_value_i,
  input wire logic [EXRG_DW-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire exrg_route_s first_route_o,
  input wire exrg_route_s second_route_o,
  input wire exrg_pins_s pins_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic rd;
  logic nrd;
  logic wr;
  assign rd = reg_rd_i && clk_en_i;
  assign nrd = rd && !WIDE;
  // Codes 0 to 7 only, so the expected one-hot is a plain shift
  assign wr = reg_wr_i && clk_en_i && reg_addr_i == 8'h0b && !reg_wdata_i[7];
  rd_answer_a: assert property (rd |=> reg_rvalid_o)
    else $error("read got no answer");
  idle_answer_a: assert property (!rd && clk_en_i |=> !reg_rvalid_o)
    else $error("answer without read");
  narrow_fixed_a: assert property (nrd && reg_addr_i == 8'h0b |=>
    reg_rdata_o[7:6] == 2'h3 && reg_rdata_o[3:2] == 2'h3)
    else $error("fixed route bits not one");
  narrow_resv_a: assert property (nrd && reg_addr_i[7:1] == 7'h06 |=>
    reg_rdata_o[7:4] == 4'h0)
    else $error("reserved bits not zero");
  mag_off_a: assert property ($past(source_magnitude_i) == 3'h0 &&
    $past(clk_en_i) |-> {first_route_o, second_route_o} == 20'h0)
    else $error("routed while off");
  one_dest_a: assert property ($onehot0(first_route_o) &&
    $onehot0(second_route_o))
    else $error("two destinations");
  pin_own_a: assert property (
    (pins_o.drive_enable & ~pins_o.digital_enable) == 8'h00)
    else $error("analog pin driven");
  route_now_a: assert property (WIDE && wr ##1 clk_en_i &&
    source_magnitude_i != 3'h0 |=>
    first_route_o.analog_input == 8'h01 << $past(reg_wdata_i[7:4], 2))
    else $error("route late or wrong");
endmodule

bind exrg_top exrg_top_checker #(.WIDE(WIDE)) chk (.*);

/* verif/exrg_sensor_net.sv */
// Sensors on the digital pins: driven pins echo, the rest show ext_i.
// Assumes the bench supplies ext_i as the sensor levels.
`timescale 1ns/1ps
module exrg_sensor_net
  import exrg_pkg::*;
(
  input wire exrg_pins_s pins_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] pad_o
);
  assign pad_o = (pins_i.drive_enable & pins_i.drive_value) |
    (~pins_i.drive_enable & ext_i);
endmodule

/* verif/test_excitation_route_and_gpio_config.sv */
// Bench: wide part as dut, narrow part as dut_n on one register port.
// Sensor models close each pin bus; each read checks both parts.
`timescale 1ns/1ps
module test_excitation_route_and_gpio_config
  import exrg_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [2:0] source_magnitude_i = 3'h1;
  logic [7:0] pin_value_i, pad_n, reg_rdata_o, rdata_n;
  logic reg_rvalid_o, rvalid_n;
  exrg_route_s first_route_o, second_route_o, r1_n, r2_n;
  exrg_pins_s pins_o, pins_n;
  int fails = 0;
  int compares = 0;
  exrg_top dut (.*);
  exrg_top #(.WIDE(1'b0)) dut_n (.*, .pin_value_i(pad_n),
    .reg_rdata_o(rdata_n), .reg_rvalid_o(rvalid_n),
    .first_route_o(r1_n), .second_route_o(r2_n), .pins_o(pins_n));
  exrg_sensor_net net (.pins_i(pins_o), .ext_i(8'h3c), .pad_o(pin_value_i));
  exrg_sensor_net net_n (.pins_i(pins_n), .ext_i(8'h3c), .pad_o(pad_n));
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic summarize();
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  // Answer is due one edge after the strobe, so no longer wait
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] n);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    cmp({reg_rvalid_o, rvalid_n, reg_rdata_o, rdata_n}, {2'h3, e, n});
  endtask
  function automatic logic [9:0] dest(input logic [3:0] c);
    if (!c[3])
      return {8'h01 << c[2:0], 2'h0};
    if (!c[2])
      return {8'h00, ~c[0], c[0]};
    return 10'h000;
  endfunction
  initial
  begin
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    rd(8'h0b, 8'hff, 8'hff);
    rd(8'h0d, 8'h00, 8'h00);
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h0b, {c[3:0], c[3:0]});
      @(negedge clk_i);
      cmp({first_route_o, second_route_o}, {dest(c[3:0]), dest(c[3:0])});
      cmp({r1_n, r2_n}, {dest({2'h0, c[1:0]}), dest({2'h0, c[1:0]})});
      rd(8'h0b, {c[3:0], c[3:0]}, {2{2'h3, c[1:0]}});
    end
    wr(8'h0b, 8'h12);
    source_magnitude_i = 3'h0;
    repeat (2) @(negedge clk_i);
    cmp({first_route_o, second_route_o}, 24'h0);
    wr(8'h0c, 8'hff);
    wr(8'h0d, 8'h0f);
    wr(8'h0e, 8'ha5);
    repeat (3) @(negedge clk_i);
    cmp({pins_o.digital_enable, pins_o.drive_enable}, 16'hfff0);
    cmp({pins_n.digital_enable, pins_n.drive_enable}, 16'h0f00);
    cmp({pins_o.drive_value, pins_n.drive_value}, 16'ha505);
    rd(8'h0c, 8'hff, 8'h0f);
    rd(8'h0e, 8'hac, 8'h0c);
    wr(8'h0f, 8'h55);
    rd(8'h0f, 8'h00, 8'h00);
    clk_en_i = 1'b0;
    wr(8'h0c, 8'h00);
    clk_en_i = 1'b1;
    rd(8'h0c, 8'hff, 8'h0f);
    rst_b_i = 1'b0;
    @(negedge clk_i);
    rst_b_i = 1'b1;
    rd(8'h0c, 8'h00, 8'h00);
    summarize();
  end
endmodule
